// ==== src/ncap_defs.svh ====
// Constants for the NAND command/address port host controller
// How it works
// - Ready/busy is open drain; host supplies pull-up and samples the line.
// - Full address goes out in five consecutive address-latch cycles.
// - Column is 13 bits: low byte first, then bits 8-12, upper lines low.
// - Row is 17 bits in cycles three to five; fifth cycle upper lines low.
// - Cycle type from latch strobes with chip select low, write strobe pulses.
// - While device busy, host issues only status, multi-status or reset; other requests are refused.
// - Read is setup command, five address cycles, then read confirm; skip_setup drops the setup command on NCAP_OP_READ.
`ifndef NCAP_DEFS_SVH
`define NCAP_DEFS_SVH
`define NCAP_CMD_READ     8'h00
`define NCAP_CMD_READ_GO  8'h30
`define NCAP_CMD_CB_GO    8'h35
`define NCAP_CMD_OCOL     8'h05
`define NCAP_CMD_OCOL_GO  8'hE0
`define NCAP_CMD_PROG     8'h80
`define NCAP_CMD_PROG_GO  8'h10
`define NCAP_CMD_ICOL     8'h85
`define NCAP_CMD_ERASE    8'h60
`define NCAP_CMD_ERASE_GO 8'hD0
`define NCAP_CMD_STAT     8'h70
`define NCAP_CMD_MSTAT    8'h71
`define NCAP_CMD_RESET    8'hFF
`define NCAP_PAGE_BYTES   13'h1080
`define NCAP_MAIN_BYTES   13'h1000
`define NCAP_ADDR_CYCLES  3'h5
`define NCAP_COL_CYCLES   3'h2
`define NCAP_PAGE_W       6
`define NCAP_STROBE_NS    40
`define NCAP_WHR_NS       60
`define NCAP_CLK_NS       20
`endif

// ==== src/ncap_pkg.sv ====
// Types for the NAND command/address port host controller
package ncap_pkg;
  typedef enum logic [3:0] {
    NCAP_OP_READ, NCAP_OP_CB_READ, NCAP_OP_OCOL, NCAP_OP_PROG,
    NCAP_OP_ICOL, NCAP_OP_CB_PROG, NCAP_OP_ERASE, NCAP_OP_STAT,
    NCAP_OP_MSTAT, NCAP_OP_RESET, NCAP_OP_DIN, NCAP_OP_DOUT
  } ncap_op_t;

  typedef struct packed {
    ncap_op_t    op;
    logic [12:0] col;
    logic [16:0] row;
    logic [7:0]  wdata;
    logic        skip_setup;
  } ncap_req_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic output_strobe_n;
    logic wp_n;
  } ncap_pins_t;

  typedef enum logic [1:0] {
    NCAP_K_CMD, NCAP_K_ADDR, NCAP_K_DATA
  } ncap_kind_t;
endpackage

// ==== src/ncap_host.sv ====
// Host controller driving a NAND command/address port
`timescale 1ns/100ps
`include "ncap_defs.svh"
module ncap_host #(
  parameter int STROBE_CYC = (`NCAP_STROBE_NS + `NCAP_CLK_NS - 1)
                             / `NCAP_CLK_NS,
  parameter int WHR_CYC    = (`NCAP_WHR_NS + `NCAP_CLK_NS - 1)
                             / `NCAP_CLK_NS
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // Request side
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire ncap_pkg::ncap_req_t req,
  input  wire logic              write_protect_n,
  output logic                   rsp_valid,
  output logic [7:0]             rsp_data,
  output logic                   rsp_refused,
  output logic                   dev_ready,
  // Flash pins
  output ncap_pkg::ncap_pins_t   pins,
  input  wire logic [7:0]        bus_lines_i,
  output logic [7:0]             bus_lines_o,
  output logic                   bus_lines_oe,
  input  wire logic              ready_busy_n
);
  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_LOW, S_HIGH, S_GAP, S_RLOW, S_RHIGH
  } st_t;

  st_t                   st, next_st;
  ncap_pkg::ncap_req_t   cur, next_cur;
  logic [3:0]            idx, next_idx, len, next_len;
  logic [3:0]            cnt, next_cnt;
  logic [7:0]            obyte, next_obyte;
  logic                  rv, next_rv, rf, next_rf;
  logic [7:0]            rd, next_rd;
  logic                  rb_m, rb_s;
  logic [7:0]            bus_m, bus_s;
  logic                  rd_op;

  // Item of the sequence: kind and byte
  function automatic logic [9:0] item(ncap_pkg::ncap_req_t r,
                                      logic [3:0] i);
    logic [7:0] c0, c1, cb;
    logic [9:0] a0, a1, a2, a3, a4;
    c0 = 8'h00;
    c1 = 8'h00;
    cb = r.col[7:0];
    a0 = {2'(ncap_pkg::NCAP_K_ADDR), cb};
    a1 = {2'(ncap_pkg::NCAP_K_ADDR), 3'h0, r.col[12:8]};
    a2 = {2'(ncap_pkg::NCAP_K_ADDR), r.row[7:0]};
    a3 = {2'(ncap_pkg::NCAP_K_ADDR), r.row[15:8]};
    a4 = {2'(ncap_pkg::NCAP_K_ADDR), 7'h00, r.row[16]};
    item = {2'(ncap_pkg::NCAP_K_CMD), 8'h00};
    case (r.op)
      ncap_pkg::NCAP_OP_READ, ncap_pkg::NCAP_OP_CB_READ: begin
        c1 = (r.op == ncap_pkg::NCAP_OP_READ) ? `NCAP_CMD_READ_GO
                                              : `NCAP_CMD_CB_GO;
        case (i)
          4'h0: item = {2'(ncap_pkg::NCAP_K_CMD), `NCAP_CMD_READ};
          4'h1: item = a0;
          4'h2: item = a1;
          4'h3: item = a2;
          4'h4: item = a3;
          4'h5: item = a4;
          default: item = {2'(ncap_pkg::NCAP_K_CMD), c1};
        endcase
      end
      ncap_pkg::NCAP_OP_PROG, ncap_pkg::NCAP_OP_CB_PROG: begin
        c0 = (r.op == ncap_pkg::NCAP_OP_PROG) ? `NCAP_CMD_PROG
                                              : `NCAP_CMD_ICOL;
        case (i)
          4'h0: item = {2'(ncap_pkg::NCAP_K_CMD), c0};
          4'h1: item = a0;
          4'h2: item = a1;
          4'h3: item = a2;
          4'h4: item = a3;
          4'h5: item = a4;
          default: item = {2'(ncap_pkg::NCAP_K_CMD), `NCAP_CMD_PROG_GO};
        endcase
      end
      ncap_pkg::NCAP_OP_ERASE: begin
        case (i)
          4'h0: item = {2'(ncap_pkg::NCAP_K_CMD), `NCAP_CMD_ERASE};
          4'h1: item = a2;
          4'h2: item = a3;
          4'h3: item = a4;
          default: item = {2'(ncap_pkg::NCAP_K_CMD), `NCAP_CMD_ERASE_GO};
        endcase
      end
      ncap_pkg::NCAP_OP_OCOL, ncap_pkg::NCAP_OP_ICOL: begin
        c0 = (r.op == ncap_pkg::NCAP_OP_OCOL) ? `NCAP_CMD_OCOL
                                              : `NCAP_CMD_ICOL;
        case (i)
          4'h0: item = {2'(ncap_pkg::NCAP_K_CMD), c0};
          4'h1: item = a0;
          4'h2: item = a1;
          default: item = {2'(ncap_pkg::NCAP_K_CMD), `NCAP_CMD_OCOL_GO};
        endcase
      end
      ncap_pkg::NCAP_OP_STAT:  item = {2'(ncap_pkg::NCAP_K_CMD), `NCAP_CMD_STAT};
      ncap_pkg::NCAP_OP_MSTAT: item = {2'(ncap_pkg::NCAP_K_CMD), `NCAP_CMD_MSTAT};
      ncap_pkg::NCAP_OP_RESET: item = {2'(ncap_pkg::NCAP_K_CMD), `NCAP_CMD_RESET};
      ncap_pkg::NCAP_OP_DIN:   item = {2'(ncap_pkg::NCAP_K_DATA), r.wdata};
      default: item = {2'(ncap_pkg::NCAP_K_DATA), 8'h00};
    endcase
  endfunction

  // Sequence length per operation
  function automatic logic [3:0] seq_len(ncap_pkg::ncap_op_t op);
    case (op)
      ncap_pkg::NCAP_OP_READ, ncap_pkg::NCAP_OP_CB_READ,
      ncap_pkg::NCAP_OP_PROG, ncap_pkg::NCAP_OP_CB_PROG:
        seq_len = 4'(`NCAP_ADDR_CYCLES) + 4'h2;
      ncap_pkg::NCAP_OP_ERASE: seq_len = 4'h5;
      ncap_pkg::NCAP_OP_OCOL:  seq_len = 4'(`NCAP_COL_CYCLES) + 4'h2;
      ncap_pkg::NCAP_OP_ICOL:  seq_len = 4'(`NCAP_COL_CYCLES) + 4'h1;
      default: seq_len = 4'h1;
    endcase
  endfunction

  // Ready/busy and bus synchroniser
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rb_m  <= 1'b0;
      rb_s  <= 1'b0;
      bus_m <= 8'h00;
      bus_s <= 8'h00;
    end else begin
      rb_m  <= ready_busy_n;
      rb_s  <= rb_m;
      bus_m <= bus_lines_i;
      bus_s <= bus_m;
    end
  end

  assign dev_ready = rb_s;
  assign rd_op     = (cur.op == ncap_pkg::NCAP_OP_STAT)
                   || (cur.op == ncap_pkg::NCAP_OP_MSTAT)
                   || (cur.op == ncap_pkg::NCAP_OP_DOUT);
  assign req_ready = (st == S_IDLE);

  // Sequencer next state
  always_comb begin
    logic [9:0] it;
    logic       busy_ok, wp_bad;
    it         = item(cur, idx);
    busy_ok    = 1'b0;
    wp_bad     = 1'b0;
    next_st    = st;
    next_cur   = cur;
    next_idx   = idx;
    next_len   = len;
    next_cnt   = cnt;
    next_obyte = obyte;
    next_rv    = 1'b0;
    next_rf    = 1'b0;
    next_rd    = rd;
    case (st)
      S_IDLE: begin
        busy_ok = (req.op == ncap_pkg::NCAP_OP_STAT)
                || (req.op == ncap_pkg::NCAP_OP_MSTAT)
                || (req.op == ncap_pkg::NCAP_OP_RESET);
        wp_bad  = !write_protect_n
                && ((req.op == ncap_pkg::NCAP_OP_PROG)
                || (req.op == ncap_pkg::NCAP_OP_CB_PROG)
                || (req.op == ncap_pkg::NCAP_OP_ERASE));
        if (req_valid) begin
          if ((!rb_s && !busy_ok) || wp_bad) begin
            next_rf = 1'b1;
            next_rv = 1'b1;
          end else begin
            next_cur = req;
            next_len = seq_len(req.op);
            next_idx = (req.op == ncap_pkg::NCAP_OP_READ && req.skip_setup)
                     ? 4'h1 : 4'h0;
            next_cnt = 4'h0;
            next_st  = S_SETUP;
          end
        end
      end
      S_SETUP: begin
        if (cur.op == ncap_pkg::NCAP_OP_DOUT) begin
          next_st  = S_RLOW;
          next_cnt = 4'(STROBE_CYC);
        end else begin
          next_obyte = it[7:0];
          next_st    = S_LOW;
          next_cnt   = 4'(STROBE_CYC);
        end
      end
      S_LOW: begin
        if (cnt == 4'h0) begin
          next_st  = S_HIGH;
          next_cnt = 4'(STROBE_CYC);
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      S_HIGH: begin
        if (cnt == 4'h0) begin
          next_idx = idx + 4'h1;
          if (idx + 4'h1 >= len) begin
            next_st  = rd_op ? S_GAP : S_IDLE;
            next_rv  = !rd_op;
            next_cnt = 4'(WHR_CYC);
          end else begin
            next_st = S_SETUP;
          end
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      S_GAP: begin
        if (cnt == 4'h0) begin
          next_st  = S_RLOW;
          next_cnt = 4'(STROBE_CYC);
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      S_RLOW: begin
        if (cnt == 4'h0) begin
          next_rd  = bus_s;
          next_st  = S_RHIGH;
          next_cnt = 4'(STROBE_CYC);
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      S_RHIGH: begin
        if (cnt == 4'h0) begin
          next_rv = 1'b1;
          next_st = S_IDLE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      default: next_st = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st    <= S_IDLE;
      cur   <= '0;
      idx   <= 4'h0;
      len   <= 4'h0;
      cnt   <= 4'h0;
      obyte <= 8'h00;
      rv    <= 1'b0;
      rf    <= 1'b0;
      rd    <= 8'h00;
    end else begin
      st    <= next_st;
      cur   <= next_cur;
      idx   <= next_idx;
      len   <= next_len;
      cnt   <= next_cnt;
      obyte <= next_obyte;
      rv    <= next_rv;
      rf    <= next_rf;
      rd    <= next_rd;
    end
  end

  // Pin drive
  always_comb begin
    logic [9:0] it;
    logic       wr;
    it                   = item(cur, idx);
    wr                   = (st == S_SETUP || st == S_LOW || st == S_HIGH)
                         && (cur.op != ncap_pkg::NCAP_OP_DOUT);
    pins.ce_n            = (st == S_IDLE);
    pins.cle             = wr && (it[9:8] == 2'(ncap_pkg::NCAP_K_CMD));
    pins.ale             = wr && (it[9:8] == 2'(ncap_pkg::NCAP_K_ADDR));
    pins.we_n            = !(st == S_LOW);
    pins.output_strobe_n = !(st == S_RLOW);
    pins.wp_n            = write_protect_n;
    bus_lines_oe         = wr;
    bus_lines_o          = obyte;
  end

  assign rsp_valid   = rv;
  assign rsp_data    = rd;
  assign rsp_refused = rf;
endmodule // ncap_host

// ==== verif/ncap_host_asserts.sv ====
// Assertion checker for the NAND port host controller
`timescale 1ns/100ps
module ncap_host_asserts (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rstn,
  // Request side
  input wire logic                 req_valid,
  input wire logic                 req_ready,
  input wire ncap_pkg::ncap_req_t  req,
  input wire logic                 write_protect_n,
  input wire logic                 rsp_valid,
  input wire logic                 rsp_refused,
  input wire logic                 dev_ready,
  // Flash pins
  input wire ncap_pkg::ncap_pins_t pins,
  input wire logic [7:0]           bus_lines_o,
  input wire logic                 bus_lines_oe,
  input wire logic                 ready_busy_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic       take;
  logic [2:0] idx;
  logic [7:0] opener;
  assign take = req_valid && req_ready;
  // Address cycles since the last command byte
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      idx    <= 3'h0;
      opener <= 8'h00;
    end else if ($rose(pins.we_n) && pins.cle) begin
      idx    <= 3'h0;
      opener <= bus_lines_o;
    end else if ($rose(pins.we_n) && pins.ale) begin
      idx    <= idx + 3'h1;
    end
  end
  wp_refuse_a: assert property (
    take && !write_protect_n && req.op inside {ncap_pkg::NCAP_OP_PROG,
    ncap_pkg::NCAP_OP_CB_PROG, ncap_pkg::NCAP_OP_ERASE}
    |=> rsp_valid && rsp_refused) else $error("protected op not refused");
  busy_refuse_a: assert property (
    take && !dev_ready && !(req.op inside {ncap_pkg::NCAP_OP_STAT,
    ncap_pkg::NCAP_OP_MSTAT, ncap_pkg::NCAP_OP_RESET})
    |=> rsp_valid && rsp_refused) else $error("busy op not refused");
  busy_sync_a: assert property (
    !ready_busy_n [*3] |-> !dev_ready) else $error("busy not seen");
  rd_cycle_a: assert property (
    !pins.output_strobe_n |-> !pins.ce_n && !pins.cle && !pins.ale
    && pins.we_n && !bus_lines_oe) else $error("bad read cycle");
  wr_cycle_a: assert property (
    !pins.we_n |-> !pins.ce_n && pins.output_strobe_n && bus_lines_oe
    && !(pins.cle && pins.ale)) else $error("bad write cycle");
  col_high_a: assert property (
    $rose(pins.we_n) && pins.ale && idx == 3'h1 && opener != 8'h60
    |-> bus_lines_o[7:5] == 3'h0) else $error("column top lines set");
  addr_five_a: assert property (
    $rose(pins.we_n) && pins.cle && bus_lines_o inside {8'h30, 8'h10}
    |-> idx == 3'h5) else $error("address count not five");
  we_width_a: assert property (
    $fell(pins.we_n) |-> !pins.we_n [*3] ##1 pins.we_n)
    else $error("write strobe width");
endmodule // ncap_host_asserts

bind ncap_host ncap_host_asserts i_chk (
  .clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .write_protect_n(write_protect_n),
  .rsp_valid(rsp_valid), .rsp_refused(rsp_refused), .dev_ready(dev_ready),
  .pins(pins), .bus_lines_o(bus_lines_o), .bus_lines_oe(bus_lines_oe),
  .ready_busy_n(ready_busy_n)
);

// ==== verif/ncap_dev_model.sv ====
// Behavioural NAND device on the far side of the host controller
`timescale 1ns/100ps
module ncap_dev_model #(
  parameter int BUSY_NS = 2010
) (
  // Pins from the host
  input  wire ncap_pkg::ncap_pins_t pins,
  input  wire logic [7:0]           bus,
  // Device drive
  output logic [7:0]                dev_q,
  output logic                      dev_oe,
  output logic                      rb_low
);
  logic [7:0]  cmd;
  logic [7:0]  ab [0:4];
  logic [2:0]  n;
  logic [12:0] col;
  logic        stat;
  logic [7:0]  din;
  int          cmd_cnt;
  event        go_busy;
  initial begin
    cmd     = 8'h00;
    n       = 3'h0;
    col     = 13'h0000;
    stat    = 1'b0;
    rb_low  = 1'b0;
    dev_q   = 8'h00;
    cmd_cnt = 0;
    din     = 8'h00;
  end
  assign dev_oe = !pins.ce_n && !pins.cle && !pins.ale && pins.we_n
                  && !pins.output_strobe_n;
  always @(go_busy) begin
    rb_low = 1'b1;
    #(BUSY_NS);
    rb_low = 1'b0;
  end
  // Latch cycles on the write strobe rise
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.cle && !pins.ale
        && (!rb_low || bus inside {8'h70, 8'h71, 8'hFF})) begin
      cmd     <= bus;
      cmd_cnt <= cmd_cnt + 1;
      n       <= 3'h0;
      stat    <= bus inside {8'h70, 8'h71};
      if (bus inside {8'h30, 8'h35} || (pins.wp_n && bus inside {8'h10, 8'hD0}))
        -> go_busy;
    end else if (!pins.ce_n && pins.ale && !pins.cle) begin
      ab[n] <= bus;
      n     <= n + 3'h1;
      if (n == 3'h1)
        col <= {bus[4:0], ab[0]};
    end else if (!pins.ce_n && !pins.ale && !pins.cle) begin
      din <= bus;
    end
  end
  // Serial output on the read strobe fall
  always @(negedge pins.output_strobe_n) begin
    if (!pins.ce_n && pins.we_n) begin
      dev_q <= stat ? {pins.wp_n, !rb_low, !rb_low, 5'h00} : col[7:0];
      if (!stat)
        col <= col + 13'h0001;
    end
  end
endmodule // ncap_dev_model

// ==== verif/ncap_host_tb_top.sv ====
// Self-checking bench of the NAND port host controller
`timescale 1ns/100ps
module ncap_host_tb_top;
  logic                 clk_sys, rstn, req_valid, req_ready, wp_n, oe;
  logic                 rsp_valid, rsp_refused, dev_ready, dev_oe, rb_low;
  logic                 got_ref;
  logic [7:0]           rsp_data, bus_o, dev_q, bus, pat, got_d;
  ncap_pkg::ncap_req_t  req;
  ncap_pkg::ncap_pins_t pins;
  wire logic            rb_n;
  int                   err_total, check_count, cyc;
  assign rb_n = rb_low ? 1'b0 : 1'b1;
  assign bus = oe ? bus_o : (dev_oe ? dev_q : pat);
  ncap_host i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .write_protect_n(wp_n),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_refused(rsp_refused),
    .dev_ready(dev_ready), .pins(pins), .bus_lines_i(bus),
    .bus_lines_o(bus_o), .bus_lines_oe(oe), .ready_busy_n(rb_n)
  );
  ncap_dev_model i_dev (
    .pins(pins), .bus(bus), .dev_q(dev_q), .dev_oe(dev_oe), .rb_low(rb_low)
  );
  task automatic chk_b(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_f(input logic e, input logic g);
    chk_b({7'h00, e}, {7'h00, g});
  endtask
  task automatic send(input ncap_pkg::ncap_op_t op,
    input logic [12:0] c = 13'h0000, input logic [16:0] r = 17'h00000,
    input logic sk = 1'b0, input logic [7:0] w = 8'h00);
    int k;
    @(posedge clk_sys);
    req       <= '{op, c, r, w, sk};
    req_valid <= 1'b1;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (rsp_valid !== 1'b1 && k < 400);
    if (rsp_valid !== 1'b1)
      err_total++;
    got_ref = rsp_refused;
    got_d   = rsp_data;
  endtask
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (dev_ready !== 1'b1 && k < 500);
    if (dev_ready !== 1'b1)
      err_total++;
  endtask
  task automatic s_status;
    send(ncap_pkg::NCAP_OP_STAT);
    chk_b(8'hE0, got_d);
    send(ncap_pkg::NCAP_OP_MSTAT);
    chk_b(8'h71, i_dev.cmd);
    chk_b(8'hE0, got_d);
  endtask
  task automatic s_read;
    int c0;
    c0 = i_dev.cmd_cnt;
    send(ncap_pkg::NCAP_OP_READ, 13'h1ABC, 17'h12345, 1'b1);
    chk_b(8'h01, 8'(i_dev.cmd_cnt - c0));
    chk_b(8'h30, i_dev.cmd);
    chk_b(8'hBC, i_dev.ab[0]);
    chk_b(8'h1A, i_dev.ab[1]);
    chk_b(8'h45, i_dev.ab[2]);
    chk_b(8'h23, i_dev.ab[3]);
    chk_b(8'h01, i_dev.ab[4]);
    chk_f(1'b0, dev_ready);
    send(ncap_pkg::NCAP_OP_READ);
    chk_f(1'b1, got_ref);
    wait_rdy();
    send(ncap_pkg::NCAP_OP_DOUT);
    chk_b(8'hBC, got_d);
    send(ncap_pkg::NCAP_OP_DOUT);
    chk_b(8'hBD, got_d);
  endtask
  task automatic s_ocol;
    send(ncap_pkg::NCAP_OP_OCOL, 13'h107F);
    chk_b(8'hE0, i_dev.cmd);
    send(ncap_pkg::NCAP_OP_DOUT);
    chk_b(8'h7F, got_d);
  endtask
  task automatic s_prog;
    ncap_pkg::ncap_op_t wo [3] = '{ncap_pkg::NCAP_OP_PROG,
      ncap_pkg::NCAP_OP_CB_PROG, ncap_pkg::NCAP_OP_ERASE};
    @(posedge clk_sys);
    wp_n <= 1'b0;
    foreach (wo[i]) begin
      send(wo[i], 13'h0000, 17'h1FFFF);
      chk_f(1'b1, got_ref);
    end
    send(ncap_pkg::NCAP_OP_STAT);
    chk_b(8'h60, got_d);
    @(posedge clk_sys);
    wp_n <= 1'b1;
    send(ncap_pkg::NCAP_OP_PROG, 13'h0000, 17'h1FFFF);
    chk_f(1'b0, got_ref);
    chk_b(8'h10, i_dev.cmd);
    send(ncap_pkg::NCAP_OP_STAT);
    chk_f(1'b0, got_ref);
    chk_b(8'h80, got_d);
    wait_rdy();
    send(ncap_pkg::NCAP_OP_ERASE, 13'h0000, 17'h1FFC0);
    chk_b(8'hD0, i_dev.cmd);
    chk_b(8'hC0, i_dev.ab[0]);
    chk_b(8'h01, i_dev.ab[2]);
    wait_rdy();
  endtask
  task automatic s_copy;
    send(ncap_pkg::NCAP_OP_CB_READ, 13'h0000, 17'h00041);
    chk_b(8'h35, i_dev.cmd);
    wait_rdy();
    send(ncap_pkg::NCAP_OP_ICOL, 13'h0800);
    chk_b(8'h85, i_dev.cmd);
    chk_b(8'h08, {3'h0, i_dev.col[12:8]});
    send(ncap_pkg::NCAP_OP_DIN, 13'h0000, 17'h00000, 1'b0, 8'hA5);
    chk_f(1'b0, got_ref);
    chk_b(8'hA5, i_dev.din);
    send(ncap_pkg::NCAP_OP_CB_PROG, 13'h0000, 17'h00080);
    chk_b(8'h10, i_dev.cmd);
    chk_b(8'h80, i_dev.ab[2]);
    wait_rdy();
    send(ncap_pkg::NCAP_OP_RESET);
    chk_b(8'hFF, i_dev.cmd);
  endtask
  task automatic close_out;
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    rstn        = 1'b0;
    req_valid   = 1'b0;
    wp_n        = 1'b1;
    req         = '0;
    pat         = 8'h5A;
    err_total   = 0;
    check_count = 0;
    cyc         = 0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    wait_rdy();
    s_status();
    s_read();
    s_ocol();
    s_prog();
    s_copy();
    close_out();
  end
  always @(posedge clk_sys) begin
    pat <= ~pat;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      close_out();
    end
  end
endmodule // ncap_host_tb_top
